/* hw/ssit_transmitter.v */
// serial position transmitter: burst capture, msb-first shift, gap monoflop
// Function
// - first falling clock edge of each burst captures the position
// - later rising edges shift out bits, most significant first
// - once all bits are sent, further pulses of the burst give zeros, except from an enabled repeat point on
// - data line stays high while no burst is in progress
// - retriggerable gap timer restarts each clock edge; expiry rearms capture
// - position is sent in plain binary, no Gray coding needed
// - optional repeat of the data after 13 or 26 pulses
// - optional parity bits or checksum appended to the word
`timescale 1ns/10ps
`default_nettype none
`include "ssit_regs.vh"
module ssit_transmitter #(
    parameter POS_BITS = `SSIT_POS_BITS, // position width
    parameter GAP_CYC = `SSIT_GAP_CYC // monoflop period in core cycles
) (
    input wire core_clk, // system clock, 100 MHz
    input wire rst, // synchronous reset, active high
    input wire ser_clk, // serial clock from receiver, idle high
    input wire [POS_BITS-1:0] position, // binary position value
    input wire [1:0] rep_mode, // 0 none, 1 repeat after 13, 2 after 26
    input wire [1:0] check_mode, // none, even parity, odd parity, checksum
    output reg ser_data, // serial data out
    output reg busy // burst in progress
);
    localparam TW = POS_BITS + `SSIT_SUM_BITS;
    localparam [15:0] REP13 = `SSIT_REP_SHORT;
    localparam [15:0] REP26 = `SSIT_REP_LONG;
    localparam [15:0] PB = POS_BITS;
    localparam [15:0] SB = `SSIT_SUM_BITS;
    localparam [31:0] GAP_CNT = (GAP_CYC < 1) ? 32'h1 : GAP_CYC;

    wire clk_s;
    reg clk_prev_q;
    reg [31:0] gap_q;
    reg [TW-1:0] word_q;
    reg [15:0] len_q;
    reg [15:0] pulse_q;
    reg [15:0] rep_at_q;
    reg rep_en_q;
    reg [POS_BITS-1:0] pos_cap_q;

    ssit_sync u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .async_in(ser_clk),
        .sync_out(clk_s)
    );

    wire fall = clk_prev_q & ~clk_s;
    wire rise = ~clk_prev_q & clk_s;

    // checksum: sum of nibbles of position
    reg [`SSIT_SUM_BITS-1:0] csum;
    integer i;
    always @* begin
        csum = {`SSIT_SUM_BITS{1'b0}};
        for (i = 0; i < POS_BITS; i = i + 1) begin
            csum = csum + ({{(`SSIT_SUM_BITS-1){1'b0}}, position[i]} << (i % `SSIT_SUM_BITS));
        end
    end

    reg [TW-1:0] new_word;
    reg [15:0] new_len;
    always @* begin
        new_word = {position, {`SSIT_SUM_BITS{1'b0}}};
        new_len = PB;
        case (check_mode)
            `SSIT_PAR_EVEN: begin
                new_word[TW-POS_BITS-1] = ^position;
                new_len = PB + 16'h1;
            end
            `SSIT_PAR_ODD: begin
                new_word[TW-POS_BITS-1] = ~(^position);
                new_len = PB + 16'h1;
            end
            `SSIT_PAR_SUM: begin
                new_word[`SSIT_SUM_BITS-1:0] = csum;
                new_len = PB + SB;
            end
            default: begin
                new_len = PB;
            end
        endcase
    end

    always @(posedge core_clk) begin
        if (rst) begin
            clk_prev_q <= 1'b1;
            gap_q <= 32'h0;
            busy <= 1'b0;
            ser_data <= 1'b1;
            word_q <= {TW{1'b0}};
            len_q <= 16'h0;
            pulse_q <= 16'h0;
            rep_at_q <= 16'h0;
            rep_en_q <= 1'b0;
            pos_cap_q <= {POS_BITS{1'b0}};
        end else begin
            clk_prev_q <= clk_s;
            if (fall | rise) begin
                gap_q <= GAP_CNT;
            end else if (gap_q != 32'h0) begin
                gap_q <= gap_q - 32'h1;
            end
            if (busy && !(fall | rise) && gap_q == 32'h1) begin
                busy <= 1'b0;
                ser_data <= 1'b1;
            end
            if (fall && !busy) begin
                busy <= 1'b1;
                word_q <= new_word;
                pos_cap_q <= position;
                len_q <= new_len;
                pulse_q <= 16'h0;
                rep_en_q <= (rep_mode == 2'h1) || (rep_mode == 2'h2);
                rep_at_q <= (rep_mode == 2'h2) ? REP26 : REP13;
            end else if (rise && busy) begin
                pulse_q <= pulse_q + 16'h1;
                if (rep_en_q && pulse_q == rep_at_q) begin
                    ser_data <= pos_cap_q[POS_BITS-1];
                    word_q <= {pos_cap_q[POS_BITS-2:0], {(TW-POS_BITS+1){1'b0}}};
                    len_q <= PB - 16'h1;
                end else if (len_q != 16'h0) begin
                    ser_data <= word_q[TW-1];
                    word_q <= {word_q[TW-2:0], 1'b0};
                    len_q <= len_q - 16'h1;
                end else begin
                    ser_data <= 1'b0;
                end
            end
        end
    end
endmodule // ssit_transmitter
`default_nettype wire

/* hw/ssit_regs.vh */
// timing and field constants for the serial position transmitter
`ifndef SSIT_REGS_VH
`define SSIT_REGS_VH
`define SSIT_CLK_MHZ 100
`define SSIT_GAP_NS 21000
`define SSIT_GAP_CYC ((`SSIT_GAP_NS * `SSIT_CLK_MHZ) / 1000)
`define SSIT_POS_BITS 25
`define SSIT_REP_SHORT 13
`define SSIT_REP_LONG 26
`define SSIT_PAR_NONE 2'h0
`define SSIT_PAR_EVEN 2'h1
`define SSIT_PAR_ODD 2'h2
`define SSIT_PAR_SUM 2'h3
`define SSIT_SUM_BITS 4
`endif

/* hw/ssit_sync.v */
// two-flop synchroniser for an asynchronous level
`timescale 1ns/10ps
`default_nettype none
module ssit_sync (
    input wire core_clk, // system clock
    input wire rst, // synchronous reset, active high
    input wire async_in, // level from outside the domain
    output wire sync_out // synchronised level
);
    reg meta_q;
    reg sync_q;
    always @(posedge core_clk) begin
        if (rst) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end
    assign sync_out = sync_q;
endmodule // ssit_sync
`default_nettype wire

/* tb/ssit_properties.sv */
// port assertions for the serial position transmitter
`timescale 1ns/10ps
`default_nettype none
module ssit_chk #(parameter POS_BITS = 25, parameter GAP_CYC = 2100) (
    input wire logic core_clk, // clock
    input wire logic rst, // reset
    input wire logic ser_clk, // serial clock
    input wire logic [POS_BITS-1:0] position, // position
    input wire logic ser_data, // data out
    input wire logic busy // burst flag
);
    logic [2:0] sy_q;
    logic [POS_BITS-1:0] cap_q;
    int n_q, ic_q;
    wire rise_w = sy_q[1] & ~sy_q[2];
    wire cap_w = sy_q[2] & ~sy_q[1] & ~busy;
    wire bit_w = cap_q[POS_BITS-1-n_q];
    always @(posedge core_clk) begin
        sy_q <= {sy_q[1:0], ser_clk};
        ic_q <= (sy_q[1] ^ sy_q[2]) ? 0 : ic_q + 1;
        n_q <= cap_w ? 0 : n_q + rise_w;
        cap_q <= cap_w ? position : cap_q;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_cap; cap_w; endsequence
    property p_cap; s_cap |=> busy; endproperty
    a_cap: assert property (p_cap) else $error("no capture");
    property p_bit; rise_w && n_q < POS_BITS |=> ser_data == $past(bit_w); endproperty
    a_bit: assert property (p_bit) else $error("wrong bit");
    property p_idle; !busy |-> ser_data; endproperty
    a_idle: assert property (p_idle) else $error("idle low");
    property p_gap; busy |-> ic_q < GAP_CYC + 4; endproperty
    a_gap: assert property (p_gap) else $error("gap late");
    sequence s_quiet; busy && !rise_w; endsequence
    sequence s_drop; busy ##1 !busy; endsequence
    property p_hold; s_quiet ##1 busy |-> $stable(ser_data); endproperty
    a_hold: assert property (p_hold) else $error("data moved off a rising edge");
    property p_release; s_drop |-> ic_q > GAP_CYC - 4; endproperty
    a_release: assert property (p_release) else $error("gap ended early");
endmodule // ssit_chk
bind ssit_transmitter ssit_chk #(.POS_BITS(POS_BITS), .GAP_CYC(GAP_CYC)) u_chk (.core_clk(core_clk), .rst(rst),
    .ser_clk(ser_clk), .position(position), .ser_data(ser_data), .busy(busy));
`default_nettype wire

/* tb/ssit_rx_model.sv */
// receiver model issuing serial clock bursts
`timescale 1ns/10ps
`default_nettype none
module ssit_rx_model #(parameter GAP_CYC = 2100) (
    input wire logic core_clk, // system clock
    output logic ser_clk = 1'b1 // serial clock, idle high
);
    task automatic burst(input int n);
        @(posedge core_clk) #1;
        repeat (2 * n) #62.5 ser_clk = ~ser_clk;
        repeat (2 * GAP_CYC) @(posedge core_clk);
    endtask
endmodule // ssit_rx_model
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the serial position transmitter
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam int P = 12, G = 40;
    logic core_clk = 1'b0, rst = 1'b1, ser_clk, ser_data, busy;
    logic [P-1:0] position = '0, word;
    logic [3:0] mode = 4'h0;
    int num_errors = 0, cmp_count = 0, i, j, k, cs;
    logic exp_bits[$];
    ssit_transmitter #(.POS_BITS(P), .GAP_CYC(G)) dut (.core_clk(core_clk), .rst(rst), .ser_clk(ser_clk),
        .position(position), .rep_mode(mode[1:0]), .check_mode(mode[3:2]), .ser_data(ser_data), .busy(busy));
    ssit_rx_model #(.GAP_CYC(G)) mdl (.core_clk(core_clk), .ser_clk(ser_clk));
    task automatic check(input string nm, input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) $display("FAIL %s exp %b got %b", nm, exp, got);
        num_errors += (got !== exp);
    endtask
    task automatic summarize(input int extra);
        num_errors += extra;
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial forever #5 core_clk = ~core_clk;
    initial #400000 summarize(1);
    always @(posedge core_clk) if (busy) position <= $urandom;
    always @(posedge ser_clk) if (exp_bits.size()) #60 check("ser_data", ser_data, exp_bits.pop_front());
    initial begin
        void'($urandom(32'he8ed998b));
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        #1 check("ser_data", ser_data, 1'b1);
        for (i = 0; i < 17; i++) begin
            @(posedge core_clk);
            word = $urandom;
            position <= word;
            mode <= i[3:0];
            for (j = 0, cs = 0; j < P; j++) cs += word[j] << (j % 4);
            for (k = 0; k < 40 - i / 16 * 35; k++) begin
                j = i % 4 == 1 ? k - 13 : i % 4 == 2 ? k - 26 : -1;
                if (j >= 0) exp_bits.push_back(j < P && word[P-1-j]);
                else if (k < P) exp_bits.push_back(word[P-1-k]);
                else exp_bits.push_back(k - P < (i / 4 == 3 ? 4 : i / 4 % 3 > 0)
                    && (i / 4 == 1 ? ^word : i / 4 == 2 ? ~^word : cs[3-k+P]));
            end
            mdl.burst(40 - i / 16 * 35);
            #1 check("busy", busy, 1'b0);
            check("ser_data", ser_data, 1'b1);
            $display("test %0d done", i);
        end
        summarize(0);
    end
endmodule // tb_top
`default_nettype wire
